// ### rmtw_top.v
// relay meter, time/date and status-row register bank
`timescale 1ns/1ps
`include "rmtw_map.vh"
module rmtw_top #(
	parameter TICK_CYCLES = `RMTW_TICK_CYCLES
) (
	input wire clk,
	input wire rst,
	input wire [15:0] reg_addr,
	input wire reg_rd,
	input wire reg_wr,
	input wire [15:0] reg_wdata,
	output wire [15:0] reg_rdata,
	output wire reg_ack,
	output wire reg_err_addr,
	output wire reg_err_value,
	input wire [15:0] synchronizing_voltage_mag,
	input wire [15:0] synchronizing_voltage_ang,
	input wire [15:0] zero_sequence_voltage_mag,
	input wire [15:0] zero_sequence_voltage_ang,
	input wire [15:0] positive_sequence_voltage_mag,
	input wire [15:0] positive_sequence_voltage_ang,
	input wire [15:0] negative_sequence_voltage_mag,
	input wire [15:0] negative_sequence_voltage_ang,
	input wire [15:0] real_power,
	input wire [15:0] reactive_power,
	input wire [15:0] power_factor,
	input wire power_factor_leading,
	input wire [15:0] system_frequency,
	input wire [7:0] front_indicator,
	input wire [2:0] contact_input_pin,
	input wire [1:0] contact_output,
	output wire [15:0] clock_seconds,
	output wire [15:0] clock_minutes,
	output wire [15:0] clock_hours,
	output wire [15:0] calendar_day,
	output wire [15:0] calendar_month,
	output wire [15:0] calendar_year,
	output wire second_tick
);
	reg [15:0] rdata_ff;
	reg ack_ff;
	reg err_addr_ff;
	reg err_value_ff;
	reg [15:0] sec_ff;
	reg [15:0] min_ff;
	reg [15:0] hour_ff;
	reg [15:0] day_ff;
	reg [15:0] month_ff;
	reg [15:0] year_ff;
	reg [31:0] div_ff;
	reg tick_ff;

	reg [15:0] nxt_rdata;
	reg nxt_hit;
	reg [15:0] nxt_sec;
	reg [15:0] nxt_min;
	reg [15:0] nxt_hour;
	reg [15:0] nxt_day;
	reg [15:0] nxt_month;
	reg [15:0] nxt_year;
	reg [31:0] nxt_div;
	reg nxt_tick;
	reg wr_time;
	reg wr_ok;

	wire [2:0] contact_input;
	wire [7:0] ind_byte;
	wire [15:0] row0_word;
	wire [15:0] row1_word;
	wire [15:0] row2_word;
	wire [31:0] tick_last;

	assign tick_last = TICK_CYCLES - 1;

	// clamp a two's-complement value into [lo, hi]
	function [15:0] clamp_s;
		input [15:0] v;
		input [15:0] lo;
		input [15:0] hi;
		begin
			clamp_s = ($signed(v) < $signed(lo)) ? lo :
				(($signed(v) > $signed(hi)) ? hi : v);
		end
	endfunction

	// clamp an unsigned value into [lo, hi]
	function [15:0] clamp_u;
		input [15:0] v;
		input [15:0] lo;
		input [15:0] hi;
		begin
			clamp_u = (v < lo) ? lo : ((v > hi) ? hi : v);
		end
	endfunction

	function in_range;
		input [15:0] v;
		input [15:0] lo;
		input [15:0] hi;
		begin
			in_range = (v >= lo) && (v <= hi);
		end
	endfunction

	function is_leap;
		input [15:0] y;
		begin
			is_leap = (y[1:0] == 2'h0) &&
				(((y % `RMTW_CENTURY) != `RMTW_ZERO) ||
				((y % `RMTW_QUAD_CENTURY) == `RMTW_ZERO));
		end
	endfunction

	function [15:0] days_in_month;
		input [15:0] m;
		input [15:0] y;
		begin
			case (m)
				`RMTW_FEB: begin
					days_in_month = is_leap(y) ? `RMTW_DIM_LEAP :
						`RMTW_DIM_FEB;
				end
				`RMTW_APR, `RMTW_JUN, `RMTW_SEP, `RMTW_NOV: begin
					days_in_month = `RMTW_DIM_SHORT;
				end
				default: begin
					days_in_month = `RMTW_DAY_MAX;
				end
			endcase
		end
	endfunction

	// contact inputs come from field wiring, so they are synchronised
	rmtw_sync #(
		.W(3)
	) u_in_sync (
		.clk(clk),
		.rst(rst),
		.d(contact_input_pin),
		.q(contact_input)
	);

	// first indicator goes to bit 15, eighth to bit 8
	assign ind_byte = {front_indicator[0], front_indicator[1],
		front_indicator[2], front_indicator[3], front_indicator[4],
		front_indicator[5], front_indicator[6], front_indicator[7]};

	rmtw_row u_row0 (
		.states(ind_byte),
		.word(row0_word)
	);

	rmtw_row u_row1 (
		.states({5'h00, contact_input}),
		.word(row1_word)
	);

	rmtw_row u_row2 (
		.states({6'h00, contact_output}),
		.word(row2_word)
	);

	// write acceptance: only time/date words, only inside their range
	always @* begin
		wr_time = 1'b1;
		wr_ok = 1'b0;
		case (reg_addr)
			`RMTW_ADR_SEC:
				wr_ok = in_range(reg_wdata, `RMTW_ZERO, `RMTW_SEC_MAX);
			`RMTW_ADR_MIN:
				wr_ok = in_range(reg_wdata, `RMTW_ZERO, `RMTW_MIN_MAX);
			`RMTW_ADR_HOUR:
				wr_ok = in_range(reg_wdata, `RMTW_ZERO, `RMTW_HOUR_MAX);
			`RMTW_ADR_DAY:
				wr_ok = in_range(reg_wdata, `RMTW_DAY_MIN,
					`RMTW_DAY_MAX);
			`RMTW_ADR_MONTH:
				wr_ok = in_range(reg_wdata, `RMTW_MONTH_MIN,
					`RMTW_MONTH_MAX);
			`RMTW_ADR_YEAR:
				wr_ok = in_range(reg_wdata, `RMTW_YEAR_MIN,
					`RMTW_YEAR_MAX);
			default: wr_time = 1'b0;
		endcase
	end

	// free-running calendar; a software write beats the tick that cycle
	always @* begin
		nxt_sec = sec_ff;
		nxt_min = min_ff;
		nxt_hour = hour_ff;
		nxt_day = day_ff;
		nxt_month = month_ff;
		nxt_year = year_ff;
		nxt_tick = 1'b0;
		nxt_div = div_ff + 32'h00000001;
		if (div_ff >= tick_last) begin
			nxt_div = 32'h00000000;
			nxt_tick = 1'b1;
		end
		if (nxt_tick) begin
			if (sec_ff >= `RMTW_SEC_MAX) begin
				nxt_sec = `RMTW_ZERO;
				if (min_ff >= `RMTW_MIN_MAX) begin
					nxt_min = `RMTW_ZERO;
					if (hour_ff >= `RMTW_HOUR_MAX) begin
						nxt_hour = `RMTW_ZERO;
						if (day_ff >= days_in_month(month_ff, year_ff)) begin
							nxt_day = `RMTW_DAY_MIN;
							if (month_ff >= `RMTW_MONTH_MAX) begin
								nxt_month = `RMTW_MONTH_MIN;
								// wraps so the year never leaves its range
								if (year_ff >= `RMTW_YEAR_MAX) begin
									nxt_year = `RMTW_YEAR_MIN;
								end else begin
									nxt_year = year_ff + 16'h0001;
								end
							end else begin
								nxt_month = month_ff + 16'h0001;
							end
						end else begin
							nxt_day = day_ff + 16'h0001;
						end
					end else begin
						nxt_hour = hour_ff + 16'h0001;
					end
				end else begin
					nxt_min = min_ff + 16'h0001;
				end
			end else begin
				nxt_sec = sec_ff + 16'h0001;
			end
		end
		if (reg_wr && wr_time && wr_ok) begin
			case (reg_addr)
				`RMTW_ADR_SEC: begin
					nxt_sec = reg_wdata;
					// restart the second so the new value lasts a full one
					nxt_div = 32'h00000000;
					nxt_tick = 1'b0;
				end
				`RMTW_ADR_MIN: nxt_min = reg_wdata;
				`RMTW_ADR_HOUR: nxt_hour = reg_wdata;
				`RMTW_ADR_DAY: nxt_day = reg_wdata;
				`RMTW_ADR_MONTH: nxt_month = reg_wdata;
				`RMTW_ADR_YEAR: nxt_year = reg_wdata;
				default: nxt_sec = nxt_sec;
			endcase
		end
	end

	// read decode; metered values are limited to their published span
	always @* begin
		nxt_hit = 1'b1;
		nxt_rdata = `RMTW_ZERO;
		case (reg_addr)
			`RMTW_ADR_SYNC_MAG:
				nxt_rdata = clamp_u(synchronizing_voltage_mag, `RMTW_ZERO,
					`RMTW_MAG_MAX);
			`RMTW_ADR_SYNC_ANG:
				nxt_rdata = clamp_s(synchronizing_voltage_ang,
					`RMTW_ANG_MIN, `RMTW_ANG_MAX);
			`RMTW_ADR_ZERO_MAG:
				nxt_rdata = clamp_u(zero_sequence_voltage_mag, `RMTW_ZERO,
					`RMTW_ZERO_MAG_MAX);
			`RMTW_ADR_ZERO_ANG:
				nxt_rdata = clamp_s(zero_sequence_voltage_ang,
					`RMTW_ANG_MIN, `RMTW_ANG_MAX);
			`RMTW_ADR_POS_MAG:
				nxt_rdata = clamp_u(positive_sequence_voltage_mag,
					`RMTW_ZERO, `RMTW_MAG_MAX);
			`RMTW_ADR_POS_ANG:
				nxt_rdata = clamp_s(positive_sequence_voltage_ang,
					`RMTW_ANG_MIN, `RMTW_ANG_MAX);
			`RMTW_ADR_NEG_MAG:
				nxt_rdata = clamp_u(negative_sequence_voltage_mag,
					`RMTW_ZERO, `RMTW_MAG_MAX);
			`RMTW_ADR_NEG_ANG:
				nxt_rdata = clamp_s(negative_sequence_voltage_ang,
					`RMTW_ANG_MIN, `RMTW_ANG_MAX);
			// -32768 would have no positive mirror, so it is pinned
			`RMTW_ADR_REAL_PWR:
				nxt_rdata = clamp_s(real_power, `RMTW_PWR_MIN,
					`RMTW_PWR_MAX);
			`RMTW_ADR_REACT_PWR:
				nxt_rdata = clamp_s(reactive_power, `RMTW_PWR_MIN,
					`RMTW_PWR_MAX);
			`RMTW_ADR_PWR_FACTOR:
				nxt_rdata = clamp_s(power_factor, `RMTW_PF_MIN,
					`RMTW_PF_MAX);
			`RMTW_ADR_PF_DIR: nxt_rdata = {15'h0000, power_factor_leading};
			`RMTW_ADR_FREQ:
				nxt_rdata = clamp_u(system_frequency, `RMTW_FREQ_MIN,
					`RMTW_FREQ_MAX);
			`RMTW_ADR_SEC: nxt_rdata = sec_ff;
			`RMTW_ADR_MIN: nxt_rdata = min_ff;
			`RMTW_ADR_HOUR: nxt_rdata = hour_ff;
			`RMTW_ADR_DAY: nxt_rdata = day_ff;
			`RMTW_ADR_MONTH: nxt_rdata = month_ff;
			`RMTW_ADR_YEAR: nxt_rdata = year_ff;
			`RMTW_ADR_ROW0: nxt_rdata = row0_word;
			`RMTW_ADR_ROW1: nxt_rdata = row1_word;
			`RMTW_ADR_ROW2: nxt_rdata = row2_word;
			default: nxt_hit = 1'b0;
		endcase
	end

	always @(posedge clk) begin
		if (rst) begin
			rdata_ff <= `RMTW_ZERO;
			ack_ff <= 1'b0;
			err_addr_ff <= 1'b0;
			err_value_ff <= 1'b0;
			sec_ff <= `RMTW_RST_SEC;
			min_ff <= `RMTW_RST_MIN;
			hour_ff <= `RMTW_RST_HOUR;
			day_ff <= `RMTW_RST_DAY;
			month_ff <= `RMTW_RST_MONTH;
			year_ff <= `RMTW_RST_YEAR;
			div_ff <= 32'h00000000;
			tick_ff <= 1'b0;
		end else begin
			sec_ff <= nxt_sec;
			min_ff <= nxt_min;
			hour_ff <= nxt_hour;
			day_ff <= nxt_day;
			month_ff <= nxt_month;
			year_ff <= nxt_year;
			div_ff <= nxt_div;
			tick_ff <= nxt_tick;
			ack_ff <= reg_rd | reg_wr;
			// a write in the same cycle as a read takes precedence
			if (reg_wr) begin
				rdata_ff <= `RMTW_ZERO;
				err_addr_ff <= ~wr_time;
				err_value_ff <= wr_time & ~wr_ok;
			end else if (reg_rd) begin
				rdata_ff <= nxt_hit ? nxt_rdata : `RMTW_ZERO;
				err_addr_ff <= ~nxt_hit;
				err_value_ff <= 1'b0;
			end else begin
				err_addr_ff <= 1'b0;
				err_value_ff <= 1'b0;
			end
		end
	end

	assign reg_rdata = rdata_ff;
	assign reg_ack = ack_ff;
	assign reg_err_addr = err_addr_ff;
	assign reg_err_value = err_value_ff;
	assign clock_seconds = sec_ff;
	assign clock_minutes = min_ff;
	assign clock_hours = hour_ff;
	assign calendar_day = day_ff;
	assign calendar_month = month_ff;
	assign calendar_year = year_ff;
	assign second_tick = tick_ff;
endmodule // rmtw_top

// ### rmtw_map.vh
// register map, ranges and timing constants for the relay meter/time/word bank
// What this block does
// - row bit0 is OR of bits 8-15, 1-7 zero
// - real power signed, clamped to +/-32767
// - power factor direction: 0 lagging, 1 leading
// - six range-checked read/write time and date registers
// - zero-sequence magnitude clamped to 0..18000
// - every angle clamped to -1800..1800
// - other voltage magnitudes clamped to 0..6000
// - every register is sixteen bits wide
`ifndef RMTW_MAP_VH
`define RMTW_MAP_VH

`define RMTW_DW 16

`define RMTW_ADR_SYNC_MAG 16'h0062
`define RMTW_ADR_SYNC_ANG 16'h0063
`define RMTW_ADR_ZERO_MAG 16'h0064
`define RMTW_ADR_ZERO_ANG 16'h0065
`define RMTW_ADR_POS_MAG 16'h0066
`define RMTW_ADR_POS_ANG 16'h0067
`define RMTW_ADR_NEG_MAG 16'h0068
`define RMTW_ADR_NEG_ANG 16'h0069
`define RMTW_ADR_REAL_PWR 16'h006A
`define RMTW_ADR_REACT_PWR 16'h006B
`define RMTW_ADR_PWR_FACTOR 16'h006C
`define RMTW_ADR_PF_DIR 16'h006D
`define RMTW_ADR_FREQ 16'h006E
`define RMTW_ADR_SEC 16'h0080
`define RMTW_ADR_MIN 16'h0081
`define RMTW_ADR_HOUR 16'h0082
`define RMTW_ADR_DAY 16'h0083
`define RMTW_ADR_MONTH 16'h0084
`define RMTW_ADR_YEAR 16'h0085
`define RMTW_ADR_ROW0 16'h0090
`define RMTW_ADR_ROW1 16'h0091
`define RMTW_ADR_ROW2 16'h0092

`define RMTW_MAG_MAX 16'h1770
`define RMTW_ZERO_MAG_MAX 16'h4650
`define RMTW_ANG_MIN 16'hF8F8
`define RMTW_ANG_MAX 16'h0708
`define RMTW_PWR_MIN 16'h8001
`define RMTW_PWR_MAX 16'h7FFF
`define RMTW_PF_MIN 16'hFF9C
`define RMTW_PF_MAX 16'h0064
`define RMTW_FREQ_MIN 16'h0028
`define RMTW_FREQ_MAX 16'h0046
`define RMTW_ZERO 16'h0000

`define RMTW_SEC_MAX 16'h003B
`define RMTW_MIN_MAX 16'h003B
`define RMTW_HOUR_MAX 16'h0017
`define RMTW_DAY_MIN 16'h0001
`define RMTW_DAY_MAX 16'h001F
`define RMTW_MONTH_MIN 16'h0001
`define RMTW_MONTH_MAX 16'h000C
`define RMTW_YEAR_MIN 16'h07D0
`define RMTW_YEAR_MAX 16'h0BB7
`define RMTW_FEB 16'h0002
`define RMTW_APR 16'h0004
`define RMTW_JUN 16'h0006
`define RMTW_SEP 16'h0009
`define RMTW_NOV 16'h000B
`define RMTW_DIM_FEB 16'h001C
`define RMTW_DIM_LEAP 16'h001D
`define RMTW_DIM_SHORT 16'h001E
`define RMTW_CENTURY 16'h0064
`define RMTW_QUAD_CENTURY 16'h0190

`define RMTW_RST_SEC 16'h0000
`define RMTW_RST_MIN 16'h0000
`define RMTW_RST_HOUR 16'h0000
`define RMTW_RST_DAY 16'h0001
`define RMTW_RST_MONTH 16'h0001
`define RMTW_RST_YEAR 16'h07D0

`define RMTW_CLK_NS 10
`define RMTW_TICK_NS 1000000000
`define RMTW_TICK_CYCLES (`RMTW_TICK_NS / `RMTW_CLK_NS)

`endif

// ### rmtw_sync.v
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rmtw_sync #(
	parameter W = 3
) (
	input wire clk,
	input wire rst,
	input wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] q_ff;

	always @(posedge clk) begin
		if (rst) begin
			meta_ff <= {W{1'b0}};
			q_ff <= {W{1'b0}};
		end else begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule // rmtw_sync

// ### rmtw_row.v
// one status row: state byte on top, summary in bit 0
`timescale 1ns/1ps
`include "rmtw_map.vh"
module rmtw_row (
	input wire [7:0] states,
	output wire [`RMTW_DW-1:0] word
);
	// bits 1..7 are held at zero so the summary is the only low bit
	assign word = {states, 7'h00, |states};
endmodule // rmtw_row

// ### rmtw_top_assertions.sv
// port checker for the meter, time and status-row bank
`timescale 1ns/1ps
module rmtw_top_chk (
	input wire clk,
	input wire rst,
	input wire [15:0] reg_addr,
	input wire reg_rd,
	input wire reg_wr,
	input wire [15:0] reg_wdata,
	input wire [15:0] reg_rdata,
	input wire reg_err_value,
	input wire [15:0] real_power,
	input wire power_factor_leading,
	input wire [7:0] front_indicator,
	input wire [15:0] clock_seconds,
	input wire [15:0] clock_minutes,
	input wire [15:0] clock_hours,
	input wire [15:0] calendar_day,
	input wire [15:0] calendar_month,
	input wire [15:0] calendar_year,
	input wire second_tick
);
	wire [7:0] fi_rev;
	wire rq;
	// first indicator sits in the top bit
	assign fi_rev = {front_indicator[0], front_indicator[1],
		front_indicator[2], front_indicator[3], front_indicator[4],
		front_indicator[5], front_indicator[6], front_indicator[7]};
	// a write wins over a read in the same cycle
	assign rq = reg_rd && !reg_wr;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_rd(a);
		rq && reg_addr == a;
	endsequence
	property p_row_sum;
		rq && reg_addr[15:2] == 14'h0024 |=>
			reg_rdata[0] == |reg_rdata[15:8] && reg_rdata[7:1] == 7'h00;
	endproperty
	a_row_sum: assert property (p_row_sum)
		else $error("row summary wrong");
	property p_row0;
		s_rd(16'h0090) |=> reg_rdata[15:8] == $past(fi_rev);
	endproperty
	a_row0: assert property (p_row0)
		else $error("indicator row wrong");
	property p_pwr;
		s_rd(16'h006A) |=> reg_rdata == ($past(real_power) == 16'h8000 ?
			16'h8001 : $past(real_power));
	endproperty
	a_pwr: assert property (p_pwr)
		else $error("real power wrong");
	property p_pfdir;
		s_rd(16'h006D) |=> reg_rdata == {15'h0000, $past(power_factor_leading)};
	endproperty
	a_pfdir: assert property (p_pfdir)
		else $error("lead lag wrong");
	property p_zmag;
		s_rd(16'h0064) |=> reg_rdata <= 16'h4650;
	endproperty
	a_zmag: assert property (p_zmag)
		else $error("zero sequence over range");
	property p_ang;
		rq && reg_addr inside {16'h0063, 16'h0065, 16'h0067, 16'h0069} |=>
			$signed(reg_rdata) >= -1800 && $signed(reg_rdata) <= 1800;
	endproperty
	a_ang: assert property (p_ang)
		else $error("angle over range");
	property p_mag;
		rq && reg_addr inside {16'h0062, 16'h0066, 16'h0068} |=>
			reg_rdata <= 16'h1770;
	endproperty
	a_mag: assert property (p_mag)
		else $error("magnitude over range");
	property p_tod;
		clock_seconds <= 16'h003B && clock_minutes <= 16'h003B &&
			clock_hours <= 16'h0017;
	endproperty
	a_tod: assert property (p_tod)
		else $error("time out of range");
	property p_date;
		calendar_day inside {[16'h0001:16'h001F]} &&
			calendar_month inside {[16'h0001:16'h000C]} &&
			calendar_year inside {[16'h07D0:16'h0BB7]};
	endproperty
	a_date: assert property (p_date)
		else $error("date out of range");
	property p_badsec;
		reg_wr && reg_addr == 16'h0080 && reg_wdata > 16'h003B |=>
			reg_err_value &&
			(clock_seconds == $past(clock_seconds) || second_tick);
	endproperty
	a_badsec: assert property (p_badsec)
		else $error("bad seconds accepted");
	property p_hour;
		reg_wr && reg_addr == 16'h0082 && reg_wdata <= 16'h0017 |=>
			!reg_err_value && clock_hours == $past(reg_wdata);
	endproperty
	a_hour: assert property (p_hour)
		else $error("hour write lost");
endmodule // rmtw_top_chk
bind rmtw_top rmtw_top_chk u_chk (.*);

// ### rmtw_master.sv
// register-port master standing in for the serial frame layer
`timescale 1ns/1ps
module rmtw_master (
	input wire clk,
	output reg [15:0] reg_addr,
	output reg reg_rd,
	output reg reg_wr,
	output reg [15:0] reg_wdata,
	input wire [15:0] reg_rdata,
	input wire reg_ack,
	input wire reg_err_addr,
	input wire reg_err_value
);
	initial begin
		reg_addr = 16'h0000;
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_wdata = 16'h0000;
	end
	// a held strobe is a new request each cycle, so it stands one cycle
	task xfer(input w, input [15:0] a, input [15:0] d,
		output [15:0] q, output [2:0] f);
		begin
			@(negedge clk);
			reg_addr = a;
			reg_wdata = d;
			reg_rd = !w;
			reg_wr = w;
			@(negedge clk);
			q = reg_rdata;
			f = {reg_ack, reg_err_addr, reg_err_value};
			reg_rd = 1'b0;
			reg_wr = 1'b0;
			// released lines show garbage, not the last value
			reg_addr = ~a;
			reg_wdata = ~d;
		end
	endtask
endmodule // rmtw_master

// ### rmtw_top_tb.sv
// self-checking bench for the meter, time and status-row bank
`timescale 1ns/1ps
module rmtw_top_tb;
	localparam TICKS = 1000;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg [15:0] mv [0:12];
	reg [7:0] leds = 8'h00;
	reg [2:0] pins = 3'h0;
	reg [1:0] outs = 2'h0;
	wire [15:0] addr, wdata, rdata, sec, mnt, hrs, day, mon, yr;
	wire rd, wr, ack, ea, ev, tick;
	integer miscompares = 0;
	integer cmp_count = 0;
	integer i;
	reg [15:0] q;
	reg [2:0] f;
	rmtw_top #(.TICK_CYCLES(TICKS)) DUT (
		.clk(clk), .rst(rst), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr),
		.reg_wdata(wdata), .reg_rdata(rdata), .reg_ack(ack),
		.reg_err_addr(ea), .reg_err_value(ev),
		.synchronizing_voltage_mag(mv[0]),
		.synchronizing_voltage_ang(mv[1]),
		.zero_sequence_voltage_mag(mv[2]),
		.zero_sequence_voltage_ang(mv[3]),
		.positive_sequence_voltage_mag(mv[4]),
		.positive_sequence_voltage_ang(mv[5]),
		.negative_sequence_voltage_mag(mv[6]),
		.negative_sequence_voltage_ang(mv[7]),
		.real_power(mv[8]), .reactive_power(mv[9]), .power_factor(mv[10]),
		.power_factor_leading(mv[11][0]), .system_frequency(mv[12]),
		.front_indicator(leds), .contact_input_pin(pins),
		.contact_output(outs), .clock_seconds(sec), .clock_minutes(mnt),
		.clock_hours(hrs), .calendar_day(day), .calendar_month(mon),
		.calendar_year(yr), .second_tick(tick));
	rmtw_master u_m (.clk(clk), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr),
		.reg_wdata(wdata), .reg_rdata(rdata), .reg_ack(ack),
		.reg_err_addr(ea), .reg_err_value(ev));
	initial begin
		forever #5 clk = ~clk;
	end
	task chk(input string n, input [15:0] e, input [15:0] g);
		begin
			cmp_count = cmp_count + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("wrong value %s exp %h got %h", n, e, g);
			end
		end
	endtask
	// flags are ack, address error, value error
	task acc(input string n, input w, input [15:0] a, input [15:0] d,
		input [15:0] e, input [2:0] ef);
		begin
			u_m.xfer(w, a, d, q, f);
			if (!w)
				chk(n, e, q);
			chk({n, " flags"}, {13'h0000, ef}, {13'h0000, f});
		end
	endtask
	task test_done;
		begin
			$display("compares %0d miscompares %0d", cmp_count, miscompares);
			if (miscompares == 0 && cmp_count > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	initial begin
		#(TICKS * 40 * 10);
		miscompares = miscompares + 1;
		test_done;
	end
	initial begin
		for (i = 0; i < 13; i = i + 1)
			mv[i] = 16'h0000;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		acc("sec", 1'b0, 16'h0080, 16'h0000, 16'h0000, 3'h4);
		acc("min", 1'b0, 16'h0081, 16'h0000, 16'h0000, 3'h4);
		acc("hour", 1'b0, 16'h0082, 16'h0000, 16'h0000, 3'h4);
		acc("day", 1'b0, 16'h0083, 16'h0000, 16'h0001, 3'h4);
		acc("month", 1'b0, 16'h0084, 16'h0000, 16'h0001, 3'h4);
		acc("year", 1'b0, 16'h0085, 16'h0000, 16'h07D0, 3'h4);
		for (i = 0; i < 8; i = i + 2) begin
			mv[i] = (i == 2) ? 16'h4651 : 16'h1771;
			acc("mag", 1'b0, 16'h0062 + i[15:0], 16'h0000,
				(i == 2) ? 16'h4650 : 16'h1770, 3'h4);
		end
		mv[2] = 16'h1771;
		acc("zmag", 1'b0, 16'h0064, 16'h0000, 16'h1771, 3'h4);
		for (i = 1; i < 8; i = i + 2) begin
			mv[i] = 16'hF8F7;
			acc("ang", 1'b0, 16'h0062 + i[15:0], 16'h0000, 16'hF8F8, 3'h4);
			mv[i] = 16'h0709;
			acc("ang", 1'b0, 16'h0062 + i[15:0], 16'h0000, 16'h0708, 3'h4);
		end
		mv[8] = 16'h8000;
		acc("pwr", 1'b0, 16'h006A, 16'h0000, 16'h8001, 3'h4);
		mv[8] = 16'h7FFF;
		acc("pwr", 1'b0, 16'h006A, 16'h0000, 16'h7FFF, 3'h4);
		mv[9] = 16'h8000;
		acc("rpwr", 1'b0, 16'h006B, 16'h0000, 16'h8001, 3'h4);
		mv[10] = 16'h0065;
		acc("pf", 1'b0, 16'h006C, 16'h0000, 16'h0064, 3'h4);
		acc("freq", 1'b0, 16'h006E, 16'h0000, 16'h0028, 3'h4);
		for (i = 0; i < 2; i = i + 1) begin
			mv[11] = i[15:0];
			acc("pfdir", 1'b0, 16'h006D, 16'h0000, i[15:0], 3'h4);
		end
		acc("row0", 1'b0, 16'h0090, 16'h0000, 16'h0000, 3'h4);
		for (i = 0; i < 8; i = i + 1) begin
			leds = 8'h01 << i;
			acc("row0", 1'b0, 16'h0090, 16'h0000,
				(16'h8000 >> i) | 16'h0001, 3'h4);
		end
		for (i = 0; i < 3; i = i + 1) begin
			pins = 3'h1 << i;
			repeat (3) @(negedge clk);
			acc("row1", 1'b0, 16'h0091, 16'h0000,
				(16'h0100 << i) | 16'h0001, 3'h4);
		end
		for (i = 0; i < 2; i = i + 1) begin
			outs = 2'h1 << i;
			acc("row2", 1'b0, 16'h0092, 16'h0000,
				(16'h0100 << i) | 16'h0001, 3'h4);
		end
		acc("sec", 1'b1, 16'h0080, 16'h003C, 16'h0000, 3'h5);
		acc("day", 1'b1, 16'h0083, 16'h0000, 16'h0000, 3'h5);
		acc("month", 1'b1, 16'h0084, 16'h000D, 16'h0000, 3'h5);
		acc("year", 1'b1, 16'h0085, 16'h0BB8, 16'h0000, 3'h5);
		acc("year", 1'b1, 16'h0085, 16'h07CF, 16'h0000, 3'h5);
		acc("gap", 1'b0, 16'h006F, 16'h0000, 16'h0000, 3'h6);
		acc("gap", 1'b0, 16'h0086, 16'h0000, 16'h0000, 3'h6);
		acc("ro", 1'b1, 16'h0062, 16'h0001, 16'h0000, 3'h6);
		acc("day", 1'b1, 16'h0083, 16'h001F, 16'h0000, 3'h4);
		acc("month", 1'b1, 16'h0084, 16'h000C, 16'h0000, 3'h4);
		acc("year", 1'b1, 16'h0085, 16'h0BB7, 16'h0000, 3'h4);
		acc("sec", 1'b1, 16'h0080, 16'h003B, 16'h0000, 3'h4);
		acc("min", 1'b1, 16'h0081, 16'h003B, 16'h0000, 3'h4);
		acc("hour", 1'b1, 16'h0082, 16'h0017, 16'h0000, 3'h4);
		chk("hours", 16'h0017, hrs);
		i = 0;
		while (tick !== 1'b1 && i < TICKS + 10) begin
			@(negedge clk);
			i = i + 1;
		end
		// last second of the range wraps every field
		chk("sec", 16'h0000, sec);
		chk("min", 16'h0000, mnt);
		chk("hour", 16'h0000, hrs);
		chk("day", 16'h0001, day);
		chk("month", 16'h0001, mon);
		chk("year", 16'h07D0, yr);
		chk("tick", 16'h0001, {15'h0000, tick});
		test_done;
	end
endmodule // rmtw_top_tb
